// >>> design/wdw_pkg.sv
// package: constants, carriers and states of the windowed reset watchdog
package wdw_pkg;
    // register map and fields
    localparam logic [15:0] WDW_CTRL_OFS = 16'h002a;
    localparam logic [7:0] WDW_CTRL_RST = 8'h7f;
    localparam int WDW_ACT_POS = 7;
    localparam int WDW_TOP_POS = 6;
    localparam logic [6:0] WDW_ROLL_FROM = 7'h40;
    localparam logic [7:0] WDW_RD_NONE = 8'h00;
    // timing
    localparam int WDW_PRESC_DEF = 16384;
    localparam int WDW_PRESC_W = 14;
    localparam int WDW_CLK_MHZ = 100;
    localparam int WDW_PULSE_NS = 500;
    localparam int WDW_PULSE_CYC = (WDW_PULSE_NS * WDW_CLK_MHZ) / 1000;
    localparam logic [5:0] WDW_PULSE_LAST = 6'(WDW_PULSE_CYC - 1);
    localparam int WDW_WAKE_SHORT = 256;
    localparam int WDW_WAKE_LONG = 4096;
    localparam logic [11:0] WDW_WAKE_SHORT_LAST = 12'(WDW_WAKE_SHORT - 1);
    localparam logic [11:0] WDW_WAKE_LONG_LAST = 12'(WDW_WAKE_LONG - 1);
    // timeout bound constants, indexed by timebase select
    localparam int WDW_TMAX0 = WDW_PRESC_DEF;
    localparam int WDW_BASE_ADD = 128;
    localparam int WDW_ADJ_ADD = 192;
    localparam int WDW_LSB_MUL = 64;
    localparam int WDW_QUARTER = 4;
    localparam int WDW_HI_TB[4] = '{4, 8, 20, 49};
    localparam int WDW_LO_TB[4] = '{59, 53, 35, 54};

    // register port request, one cycle per access
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdw_bus_req_t;

    // timeout bounds in oscillator periods
    typedef struct packed {
        logic [23:0] tmin;
        logic [23:0] tmax;
    } wdw_bounds_t;

    typedef enum logic [1:0] {WDW_RUN, WDW_HALT_ONE, WDW_FROZEN, WDW_WAKE_WAIT} wdw_state_t;
endpackage

// >>> design/wdw_prescaler.sv
// module: free-running prescaler that paces the watchdog countdown
`timescale 1ns/1ns
`default_nettype none
module wdw_prescaler
    import wdw_pkg::*;
#(
    parameter int PRESCALE = WDW_PRESC_DEF
)(
    input wire logic clk_i,
    input wire logic reset_i,
    output logic tick_o,
    output logic [WDW_PRESC_W-1:0] phase_o
);
    localparam logic [WDW_PRESC_W-1:0] LAST = WDW_PRESC_W'(PRESCALE - 1);

    // phase is never cleared by register writes, so timeouts carry jitter
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            phase_o <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= (phase_o == LAST);
            phase_o <= (phase_o == LAST) ? '0 : phase_o + 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> design/wdw_bounds.sv
// module: timeout bound calculator for the selected timebase
`timescale 1ns/1ns
`default_nettype none
module wdw_bounds
    import wdw_pkg::*;
(
    input wire logic [1:0] timebase_select_i,
    input wire logic [5:0] step_count_i,
    output var wdw_bounds_t bounds_o
);
    int hi;
    int lo;
    int cnt;
    int k;
    int base_min;
    int step_term;

    // divisions round down; tmin takes the adjusted term from a quarter of hi on, tmax only past it
    always_comb
    begin
        hi = WDW_HI_TB[timebase_select_i];
        lo = WDW_LO_TB[timebase_select_i];
        cnt = int'(step_count_i);
        k = (WDW_QUARTER * cnt) / hi;
        base_min = (lo + WDW_BASE_ADD) * WDW_LSB_MUL;
        step_term = WDW_TMAX0 * (cnt - k) + (WDW_ADJ_ADD + lo) * WDW_LSB_MUL * k;
        if (cnt < hi / WDW_QUARTER)
            bounds_o.tmin = 24'(base_min + WDW_TMAX0 * cnt);
        else
            bounds_o.tmin = 24'(base_min + step_term);
        if (cnt <= hi / WDW_QUARTER)
            bounds_o.tmax = 24'(WDW_TMAX0 + WDW_TMAX0 * cnt);
        else
            bounds_o.tmax = 24'(WDW_TMAX0 + step_term);
    end
endmodule
`default_nettype wire

// >>> design/wdw_watchdog.sv
// module: windowed reset watchdog with control register and reset pulse
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - counter steps down once per prescaler period of 16384 clocks
// - active watchdog pulses reset low about 500ns when counter goes 40h to 3Fh
// - counter runs even when inactive; only the reset needs activation
// - comes up disabled; once active stays active until device reset
// - write with activation set and top bit clear resets at once
// - halt while active gives a reset instead of halting
// - six low counter bits give 64 timeout steps of one period each
// - writes never clear the prescaler, so timeout lies between bounds
// - bound constants follow timebase select: 4/59, 8/53, 20/35, 49/54
// - minimum and maximum bounds computed per step count from those constants
// - straps give hardware-enabled watchdog and halt-reset choice
// - control register reads 7Fh after reset
// - hardware option keeps watchdog active; activation bit has no effect
// - halt without reset: one more step, freeze, resume 256/4096 clocks after wake
module wdw_watchdog
    import wdw_pkg::*;
#(
    parameter int PRESCALE = WDW_PRESC_DEF
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire wdw_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic [1:0] timebase_select_i,
    input wire logic hw_wdg_opt_i,
    input wire logic halt_reset_option_i,
    input wire logic halt_req_i,
    input wire logic ext_wake_i,
    input wire logic wake_long_sel_i,
    output logic wdg_reset_n_o,
    output logic halt_enter_o,
    output logic watchdog_active_o,
    output var wdw_bounds_t bounds_o
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic hw_opt;
    logic halt_opt;
    logic wake;
    logic tick;
    logic [WDW_PRESC_W-1:0] phase;
    logic [6:0] counter_r;
    logic activation_bit_r;
    logic active_eff;
    wdw_state_t state_r;
    logic [11:0] wake_cnt_r;
    logic [5:0] pulse_cnt_r;
    logic wr_hit;
    logic rd_hit;
    logic dec_en;
    logic roll;
    logic sw_fire;
    logic halt_fire;
    logic fire;
    wdw_bounds_t bounds_w;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // straps and the wake line arrive from pins, two flops each
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
        end
        else
        begin
            pin_meta_r <= {ext_wake_i, halt_reset_option_i, hw_wdg_opt_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign hw_opt = pin_sync_r[0];
    assign halt_opt = pin_sync_r[1];
    assign wake = pin_sync_r[2];

    // ----------------------------------------------------------------
    // prescaler and bound calculator
    // ----------------------------------------------------------------
    wdw_prescaler #(
        .PRESCALE(PRESCALE)
    ) u_presc (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tick_o(tick),
        .phase_o(phase)
    );

    wdw_bounds u_bounds (
        .timebase_select_i(timebase_select_i),
        .step_count_i(counter_r[5:0]),
        .bounds_o(bounds_w)
    );

    // ----------------------------------------------------------------
    // decode and reset causes
    // ----------------------------------------------------------------
    assign wr_hit = bus_i.wr && (bus_i.addr == WDW_CTRL_OFS);
    assign rd_hit = bus_i.rd && (bus_i.addr == WDW_CTRL_OFS);
    // hardware option overrides the activation bit
    assign active_eff = activation_bit_r || hw_opt;
    // counting stops once frozen in halt
    assign dec_en = tick && ((state_r == WDW_RUN) || (state_r == WDW_HALT_ONE));
    assign roll = dec_en && (counter_r == WDW_ROLL_FROM);
    // a clear top bit on write fires at once; already active also counts
    assign sw_fire = wr_hit && !bus_i.wdata[WDW_TOP_POS]
        && (bus_i.wdata[WDW_ACT_POS] || active_eff);
    assign halt_fire = halt_req_i && active_eff && halt_opt;
    // a refresh in the rolling cycle wins, it is what software meant
    assign fire = (roll && active_eff && !wr_hit) || sw_fire || halt_fire;

    // ----------------------------------------------------------------
    // countdown
    // ----------------------------------------------------------------
    // free-running whether active or not; a write reloads all seven bits
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            counter_r <= WDW_CTRL_RST[6:0];
        else if (wr_hit)
            counter_r <= bus_i.wdata[6:0];
        else if (dec_en)
            counter_r <= counter_r - 7'h01;
    end

    // ----------------------------------------------------------------
    // activation bit
    // ----------------------------------------------------------------
    // set-only from software; only a device reset clears it
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            activation_bit_r <= WDW_CTRL_RST[WDW_ACT_POS];
        else if (wr_hit && bus_i.wdata[WDW_ACT_POS])
            activation_bit_r <= 1'b1;
    end

    // ----------------------------------------------------------------
    // halt handling
    // ----------------------------------------------------------------
    // halt without reset: one more step, freeze, resume after wake delay
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_r <= WDW_RUN;
            wake_cnt_r <= 12'h000;
        end
        else
        begin
            unique case (state_r)
                WDW_RUN:
                begin
                    if (halt_req_i && !halt_fire)
                        state_r <= WDW_HALT_ONE;
                end
                WDW_HALT_ONE:
                begin
                    if (wake)
                    begin
                        state_r <= WDW_WAKE_WAIT;
                        wake_cnt_r <= wake_long_sel_i ? WDW_WAKE_LONG_LAST
                            : WDW_WAKE_SHORT_LAST;
                    end
                    else if (dec_en)
                        state_r <= WDW_FROZEN;
                end
                WDW_FROZEN:
                begin
                    if (wake)
                    begin
                        state_r <= WDW_WAKE_WAIT;
                        wake_cnt_r <= wake_long_sel_i ? WDW_WAKE_LONG_LAST
                            : WDW_WAKE_SHORT_LAST;
                    end
                end
                WDW_WAKE_WAIT:
                begin
                    if (wake_cnt_r == 12'h000)
                        state_r <= WDW_RUN;
                    else
                        wake_cnt_r <= wake_cnt_r - 12'h001;
                end
            endcase
        end
    end

    // halt is granted only when it does not turn into a reset
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            halt_enter_o <= 1'b0;
        else
            halt_enter_o <= halt_req_i && !halt_fire;
    end

    // ----------------------------------------------------------------
    // reset pulse
    // ----------------------------------------------------------------
    // fixed-length low pulse; causes during a running pulse are absorbed
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wdg_reset_n_o <= 1'b1;
            pulse_cnt_r <= 6'h00;
        end
        else if (wdg_reset_n_o)
        begin
            if (fire)
            begin
                wdg_reset_n_o <= 1'b0;
                pulse_cnt_r <= WDW_PULSE_LAST;
            end
        end
        else if (pulse_cnt_r == 6'h00)
            wdg_reset_n_o <= 1'b1;
        else
            pulse_cnt_r <= pulse_cnt_r - 6'h01;
    end

    // ----------------------------------------------------------------
    // register read and status outputs
    // ----------------------------------------------------------------
    // read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rdata_o <= WDW_RD_NONE;
        else if (rd_hit)
            rdata_o <= {activation_bit_r, counter_r};
        else
            rdata_o <= WDW_RD_NONE;
    end

    // bounds track the live step count and timebase
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            bounds_o <= '0;
            watchdog_active_o <= 1'b0;
        end
        else
        begin
            bounds_o <= bounds_w;
            watchdog_active_o <= active_eff;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    AST_DEC_ON_TICK: assert property (
        (dec_en && !wr_hit) |=> (counter_r == $past(counter_r) - 7'h01))
        else $error("counter did not step on prescaler tick");

    AST_ROLL_RESET: assert property (
        (roll && active_eff && !wr_hit && wdg_reset_n_o) |=> !wdg_reset_n_o)
        else $error("rollover while active gave no reset");

    AST_PULSE_LEN: assert property (
        $fell(wdg_reset_n_o) |-> ##49 !wdg_reset_n_o ##1 wdg_reset_n_o)
        else $error("reset pulse length wrong");

    AST_FREE_NO_RESET: assert property (
        (roll && !active_eff && !wr_hit && !halt_req_i) |-> !fire)
        else $error("inactive rollover fired a reset");

    AST_STAY_ACTIVE: assert property (
        activation_bit_r |=> activation_bit_r)
        else $error("activation bit cleared without reset");

    AST_SW_RESET: assert property (
        (wr_hit && bus_i.wdata[WDW_ACT_POS] && !bus_i.wdata[WDW_TOP_POS] && wdg_reset_n_o)
        |=> !wdg_reset_n_o)
        else $error("software reset write ignored");

    AST_HALT_RESET: assert property (
        (halt_req_i && active_eff && halt_opt && wdg_reset_n_o)
        |=> (!wdg_reset_n_o && !halt_enter_o))
        else $error("halt while active did not reset");

    AST_PRESC_FREE: assert property (
        wr_hit |=> ((phase == $past(phase) + 14'h0001) || (phase == 14'h0000)))
        else $error("prescaler disturbed by write");

    AST_BOUND_2MS: assert property (
        (timebase_select_i == 2'h0 && counter_r[5:0] == 6'h00)
        |=> (bounds_o.tmin == 24'h002ec0 && bounds_o.tmax == 24'h004000))
        else $error("bounds for step zero wrong");

    AST_RESET_VALUE: assert property (
        $past(reset_i) |-> (counter_r == 7'h7f && !activation_bit_r))
        else $error("control register not 7Fh after reset");

    AST_HW_ACTIVE: assert property (
        (roll && hw_opt && !wr_hit && wdg_reset_n_o) |=> !wdg_reset_n_o)
        else $error("hardware option rollover gave no reset");

    AST_FROZEN_HOLD: assert property (
        (state_r == WDW_FROZEN && !wr_hit) |=> $stable(counter_r))
        else $error("counter moved while frozen in halt");

    AST_HALT_GRANT: assert property (
        (state_r == WDW_RUN && halt_req_i && !halt_fire)
        |=> (state_r == WDW_HALT_ONE && halt_enter_o))
        else $error("halt without reset was not granted");

    AST_WAKE_HOLD: assert property (
        (state_r == WDW_WAKE_WAIT && !wr_hit) |=> $stable(counter_r))
        else $error("counter moved during wake delay");

    AST_WAKE_SHORT: assert property (
        ($rose(state_r == WDW_WAKE_WAIT) && !$past(wake_long_sel_i))
        |-> ##255 (state_r == WDW_WAKE_WAIT) ##1 (state_r == WDW_RUN))
        else $error("short wake delay has wrong length");

    AST_READ_DATA: assert property (
        rd_hit |=> (rdata_o == {$past(activation_bit_r), $past(counter_r)}))
        else $error("read data does not match control register");

    AST_KEEP_ACT: assert property (
        (wr_hit && !bus_i.wdata[WDW_ACT_POS])
        |=> (activation_bit_r == $past(activation_bit_r)))
        else $error("write of zero changed activation bit");

    AST_HW_ALWAYS: assert property (
        hw_opt |=> watchdog_active_o)
        else $error("hardware option did not keep watchdog active");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// testbench: self-checking bench for the windowed reset watchdog
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import wdw_pkg::*;
;
    // short prescaler keeps every timeout within 64 periods of 16 cycles, 1024 cycles
    localparam int P = 16;
    localparam int LIMIT = 20000;
    logic clk_i;
    logic reset_i;
    logic hw_opt;
    logic halt_opt;
    logic halt_req;
    logic wake;
    logic wake_long;
    logic [1:0] tb_sel;
    wdw_bus_req_t bus_r;
    logic [7:0] rdata;
    logic rst_n;
    logic halt_ent;
    logic active;
    wdw_bounds_t bnd;
    int n_mismatch;
    int checked;
    int cyc;

    wdw_watchdog #(.PRESCALE(P)) wdw_watchdog_i (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_r),
        .rdata_o(rdata), .timebase_select_i(tb_sel), .hw_wdg_opt_i(hw_opt),
        .halt_reset_option_i(halt_opt), .halt_req_i(halt_req), .ext_wake_i(wake),
        .wake_long_sel_i(wake_long), .wdg_reset_n_o(rst_n), .halt_enter_o(halt_ent),
        .watchdog_active_o(active), .bounds_o(bnd));

    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    always #5 clk_i = ~clk_i;

    // a stuck wait ends the run as a failure instead of hanging
    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report;
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_r <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_r.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus_r <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_r.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // straps pass two flops, so a few edges follow the release
    task automatic do_reset;
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wait_low(input int lim, output int n);
        n = 0;
        while (rst_n !== 1'b0 && n < lim)
        begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask

    task automatic pulse_len(output int n);
        n = 0;
        while (rst_n === 1'b0 && n < 200)
        begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask

    task automatic halt_pulse;
        @(posedge clk_i);
        halt_req <= 1'b1;
        @(posedge clk_i);
        halt_req <= 1'b0;
        #1;
    endtask

    // expected bounds, tmin in the upper half
    function automatic logic [47:0] exp_b(input int s, input int c);
        int hi, lo, q, m, base, mid;
        hi = WDW_HI_TB[s];
        lo = WDW_LO_TB[s];
        q = hi / 4;
        m = (4 * c) / hi;
        mid = 16384 * (c - m) + (192 + lo) * 64 * m;
        base = (lo + 128) * 64;
        exp_b[47:24] = 24'(c < q ? base + 16384 * c : base + mid);
        exp_b[23:0] = 24'(c <= q ? 16384 + 16384 * c : 16384 + mid);
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_vals;
        logic [7:0] d;
        rd(WDW_CTRL_OFS, d);
        chk(d, WDW_CTRL_RST);
        chk(active, 1'b0);
        wr(16'h0030, 8'hc0);
        rd(16'h0030, d);
        chk(d, WDW_RD_NONE);
        rd(WDW_CTRL_OFS, d);
        chk(d[7], 1'b0);
    endtask

    task automatic t_free_run;
        logic [7:0] d;
        logic low;
        wr(WDW_CTRL_OFS, 8'h45);
        repeat (2 * P) @(posedge clk_i);
        rd(WDW_CTRL_OFS, d);
        chk(d == 8'h43 || d == 8'h42, 1'b1);
        low = 1'b0;
        wr(WDW_CTRL_OFS, 8'h41);
        // inactive crossing of 40h must stay quiet
        repeat (3 * P)
        begin
            @(posedge clk_i);
            #1 if (rst_n !== 1'b1) low = 1'b1;
        end
        chk(low, 1'b0);
        rd(WDW_CTRL_OFS, d);
        chk(d[7:6], 2'b00);
    endtask

    task automatic t_timeout;
        int n;
        wr(WDW_CTRL_OFS, 8'hc2);
        wait_low(4 * P, n);
        chk(n >= 2 * P - 2 && n <= 3 * P + 2, 1'b1);
        pulse_len(n);
        chk(24'(n), 24'(WDW_PULSE_CYC));
        do_reset();
        chk(active, 1'b0);
    endtask

    task automatic t_stay_active;
        logic [7:0] d;
        int n;
        wr(WDW_CTRL_OFS, 8'hff);
        wr(WDW_CTRL_OFS, 8'h7f);
        rd(WDW_CTRL_OFS, d);
        chk(d[7], 1'b1);
        chk(active, 1'b1);
        wr(WDW_CTRL_OFS, 8'h80);
        wait_low(2, n);
        chk(rst_n, 1'b0);
        pulse_len(n);
        do_reset();
    endtask

    task automatic t_halt_reset;
        int n;
        wr(WDW_CTRL_OFS, 8'hff);
        halt_pulse();
        chk(halt_ent, 1'b0);
        wait_low(2, n);
        chk(rst_n, 1'b0);
        pulse_len(n);
        // halt-reset option off: an active watchdog lets the halt through
        @(posedge clk_i);
        halt_opt <= 1'b0;
        do_reset();
        wr(WDW_CTRL_OFS, 8'hff);
        halt_pulse();
        chk(halt_ent, 1'b1);
        chk(rst_n, 1'b1);
        @(posedge clk_i);
        halt_opt <= 1'b1;
        do_reset();
    endtask

    // inactive halt: grant, one step, freeze, resume after the wake delay
    task automatic t_halt_freeze;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        halt_pulse();
        chk(halt_ent, 1'b1);
        chk(rst_n, 1'b1);
        repeat (2 * P) @(posedge clk_i);
        rd(WDW_CTRL_OFS, a);
        repeat (3 * P) @(posedge clk_i);
        rd(WDW_CTRL_OFS, b);
        chk(b, a);
        @(posedge clk_i);
        wake <= 1'b1;
        // still frozen well inside the 256-clock resume wait
        repeat (200) @(posedge clk_i);
        rd(WDW_CTRL_OFS, c);
        chk(c, b);
        repeat (100) @(posedge clk_i);
        wake <= 1'b0;
        rd(WDW_CTRL_OFS, c);
        chk(c < b, 1'b1);
        halt_pulse();
        repeat (2 * P) @(posedge clk_i);
        rd(WDW_CTRL_OFS, a);
        @(posedge clk_i);
        wake_long <= 1'b1;
        wake <= 1'b1;
        repeat (WDW_WAKE_SHORT + 3 * P) @(posedge clk_i);
        wake <= 1'b0;
        rd(WDW_CTRL_OFS, b);
        chk(b, a);
        @(posedge clk_i);
        wake_long <= 1'b0;
        do_reset();
    endtask

    task automatic t_hw_opt;
        logic [7:0] d;
        int n;
        @(posedge clk_i);
        hw_opt <= 1'b1;
        do_reset();
        repeat (2) @(posedge clk_i);
        #1 chk(active, 1'b1);
        rd(WDW_CTRL_OFS, d);
        chk(d[7], 1'b0);
        wr(WDW_CTRL_OFS, 8'h42);
        wait_low(4 * P, n);
        chk(rst_n, 1'b0);
        pulse_len(n);
        @(posedge clk_i);
        hw_opt <= 1'b0;
        do_reset();
    endtask

    // counter read on both sides of the sample guards against a tick
    task automatic t_bounds;
        logic [7:0] a;
        logic [7:0] b;
        logic [47:0] e;
        wdw_bounds_t s;
        for (int t = 0; t < 4; t++)
        begin
            for (int k = 0; k < 2; k++)
            begin
                @(posedge clk_i);
                tb_sel <= 2'(t);
                wr(WDW_CTRL_OFS, k == 0 ? 8'h7f : 8'h42);
                for (int r = 0; r < 4; r++)
                begin
                    rd(WDW_CTRL_OFS, a);
                    @(posedge clk_i);
                    #1 s = bnd;
                    rd(WDW_CTRL_OFS, b);
                    if (a === b)
                        break;
                end
                e = exp_b(t, int'(a[5:0]));
                chk(s.tmin, e[47:24]);
                chk(s.tmax, e[23:0]);
            end
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        clk_i = 1'b0;
        reset_i = 1'b1;
        hw_opt = 1'b0;
        halt_opt = 1'b1;
        halt_req = 1'b0;
        wake = 1'b0;
        wake_long = 1'b0;
        tb_sel = 2'b00;
        bus_r = '0;
        n_mismatch = 0;
        checked = 0;
        cyc = 0;
        do_reset();
        t_reset_vals();
        t_free_run();
        t_timeout();
        t_stay_active();
        t_halt_reset();
        t_halt_freeze();
        t_hw_opt();
        t_bounds();
        final_report();
    end
endmodule
`default_nettype wire
